// File: rtl/sps_stats.sv
// sps_stats: per-port unknown-source, memory-protect and per-priority transmit counters
// assumes: event inputs synchronous to pclk, one-cycle pulses; APB slave on pclk
//
// How it works
// RL1 - count good unicast frames from unknown source, 64 to max length
// RL2 - add unknown-source unicast frame length into 32-bit byte counter
// RL3 - count good multicast frames from unknown source, 64 to max length
// RL4 - add unknown-source multicast frame length into its byte counter
// RL5 - count good broadcast frames from unknown source, 64 to max length
// RL6 - add unknown-source broadcast frame length into its byte counter
// RL7 - count every egress frame with a memory-protect crc error
// RL8 - a full counter set for each port, port count a parameter
// RL9 - eight transmit frame counters per port, one per priority
// RL10 - collision retries do not add a count
// RL11 - pause frames are not counted per priority
// RL12 - carrier sense errors do not stop the per-priority count
// RL13 - per-priority byte counter follows each counted transmit frame
// RL14 - count frames dropped on priority fifo start-of-packet overrun
// RL15 - per-priority drop byte counter follows each counted drop
// RL16 - counters reset to zero, read-only, wrap modulo two to thirty-two
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "sps_stats_map.svh"

module sps_stats
  import sps_stats_pkg::*;
#(
  parameter int NPORTS = 5,                    // 5 or 9 port switch
  parameter int NPRI   = `SPS_NUM_PRI,         // transmit priorities
  parameter int PW     = (NPORTS > 1) ? $clog2(NPORTS) : 1
) (
  input  wire logic                pclk,       // bus and counter clock
  input  wire logic                presetn,    // async reset, active low
  input  wire logic                clk_en,     // freezes all state when low
  // apb slave
  input  wire logic                psel,       // slave select
  input  wire logic                penable,    // access phase
  input  wire logic                pwrite,     // write (refused with pslverr, read-only)
  input  wire logic [15:0]         paddr,      // byte address
  input  wire logic [31:0]         pwdata,     // write data (unused)
  output logic      [31:0]         prdata,     // read data
  output logic                     pready,     // transfer done
  output logic                     pslverr,    // unmapped or write
  // lookup engine receive events
  input  wire logic                rx_valid,   // one frame reported
  input  wire logic [PW-1:0]       rx_port,    // receiving port
  input  wire sps_dst_e            rx_dst,     // destination class
  input  wire logic                rx_data,    // data frame, not control
  input  wire logic                rx_sa_unknown, // source not in table
  input  wire logic                rx_err,     // crc, align or code error
  input  wire sps_len_t            rx_len,     // frame length in bytes
  input  wire sps_len_t            receive_max_frame_length, // upper limit
  // transmit events
  input  wire logic                tx_valid,   // frame left a priority fifo
  input  wire logic [PW-1:0]       tx_port,    // egress port
  input  wire logic [2:0]          tx_pri,     // fifo priority
  input  wire logic                tx_retry,   // collision retry attempt
  input  wire logic                tx_pause,   // pause frame
  input  wire sps_len_t            tx_len,     // frame length
  input  wire logic                mp_valid,   // memory-protect crc error
  input  wire logic [PW-1:0]       mp_port,    // egress port of that frame
  input  wire logic                drop_valid, // sop overrun drop
  input  wire logic [PW-1:0]       drop_port,  // egress port
  input  wire logic [2:0]          drop_pri,   // fifo priority
  input  wire sps_len_t            drop_len    // dropped frame length
);

  localparam int NSC = `SPS_NUM_SCALAR;
  localparam int IW  = `SPS_WORD_IDX_W;

  // counters, all at 32 bits so they wrap on their own
  sps_cnt_t sc_q     [NPORTS][NSC];            // RL8
  sps_cnt_t pri_q    [NPORTS][NPRI];           // RL9
  sps_cnt_t prib_q   [NPORTS][NPRI];
  sps_cnt_t drp_q    [NPORTS][NPRI];
  sps_cnt_t drpb_q   [NPORTS][NPRI];

  // receive qualification
  logic rx_good;
  assign rx_good = rx_valid && rx_data && rx_sa_unknown && !rx_err
                   && (rx_len >= `SPS_MIN_GOOD_LEN)
                   && (rx_len <= receive_max_frame_length);

  logic tx_count;
  // carrier sense status is deliberately not an input here
  assign tx_count = tx_valid && !tx_retry && !tx_pause; // RL10 RL11 RL12

  logic [31:0] rx_len32;
  logic [31:0] tx_len32;
  logic [31:0] dr_len32;
  assign rx_len32 = {18'h0, rx_len};
  assign tx_len32 = {18'h0, tx_len};
  assign dr_len32 = {18'h0, drop_len};

  genvar gp;
  genvar gq;
  generate
    for (gp = 0; gp < NPORTS; gp++) begin : g_port
      logic rx_hit;
      assign rx_hit = rx_good && (rx_port == PW'(gp));

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          for (int k = 0; k < NSC; k++) begin
            sc_q[gp][k] <= `SPS_CNT_RESET; // RL16
          end
        end else if (clk_en) begin
          if (rx_hit && rx_dst == SPS_DST_UNI) begin
            sc_q[gp][0] <= sc_q[gp][0] + 32'h1;          // RL1
            sc_q[gp][1] <= sc_q[gp][1] + rx_len32;       // RL2
          end
          if (rx_hit && rx_dst == SPS_DST_MLT) begin
            sc_q[gp][2] <= sc_q[gp][2] + 32'h1;          // RL3
            sc_q[gp][3] <= sc_q[gp][3] + rx_len32;       // RL4
          end
          if (rx_hit && rx_dst == SPS_DST_BRD) begin
            sc_q[gp][4] <= sc_q[gp][4] + 32'h1;          // RL5
            sc_q[gp][5] <= sc_q[gp][5] + rx_len32;       // RL6
          end
          if (mp_valid && mp_port == PW'(gp)) begin
            sc_q[gp][6] <= sc_q[gp][6] + 32'h1;          // RL7
          end
        end
      end

      for (gq = 0; gq < NPRI; gq++) begin : g_pri
        logic tx_hit;
        logic dr_hit;
        assign tx_hit = tx_count && tx_port == PW'(gp) && tx_pri == 3'(gq);
        assign dr_hit = drop_valid && drop_port == PW'(gp) && drop_pri == 3'(gq);

        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            pri_q[gp][gq]  <= `SPS_CNT_RESET; // RL16
            prib_q[gp][gq] <= `SPS_CNT_RESET;
          end else if (clk_en && tx_hit) begin
            pri_q[gp][gq]  <= pri_q[gp][gq] + 32'h1;     // RL9
            prib_q[gp][gq] <= prib_q[gp][gq] + tx_len32; // RL13
          end
        end

        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            drp_q[gp][gq]  <= `SPS_CNT_RESET; // RL16
            drpb_q[gp][gq] <= `SPS_CNT_RESET;
          end else if (clk_en && dr_hit) begin
            drp_q[gp][gq]  <= drp_q[gp][gq] + 32'h1;     // RL14
            drpb_q[gp][gq] <= drpb_q[gp][gq] + dr_len32; // RL15
          end
        end
      end
    end
  endgenerate

  // apb read decode
  logic [15:0] port_sel;
  logic [IW-1:0] widx;
  assign port_sel = 16'(paddr >> `SPS_PORT_STRIDE_LOG2);
  assign widx     = paddr[IW+1:2];

  logic [31:0] rd_d;
  logic        hit_d;
  always_comb begin
    int p;
    int w;
    p     = int'(port_sel);
    w     = int'(widx);
    rd_d  = `SPS_RDATA_ERR;
    hit_d = 1'b0;
    if (p < NPORTS && paddr[1:0] == 2'b00) begin
      if (w < NSC) begin
        rd_d  = sc_q[p][w];
        hit_d = 1'b1;
      end else if (w >= 8 && w < 8 + NPRI) begin
        rd_d  = pri_q[p][w - 8];
        hit_d = 1'b1;
      end else if (w >= 16 && w < 16 + NPRI) begin
        rd_d  = prib_q[p][w - 16];
        hit_d = 1'b1;
      end else if (w >= 24 && w < 24 + NPRI) begin
        rd_d  = drp_q[p][w - 24];
        hit_d = 1'b1;
      end else if (w >= 32 && w < 32 + NPRI) begin
        rd_d  = drpb_q[p][w - 32];
        hit_d = 1'b1;
      end
    end
  end

  // one wait state: answer registered in the access cycle, done next edge
  logic pend_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q  <= 1'b0;
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && penable && !pready && !pend_q) begin
        pend_q  <= 1'b1;
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0 : rd_d;
        // writes refused: counters are read-only
        pslverr <= pwrite || !hit_d; // RL16
      end else begin
        pend_q  <= 1'b0;
        pready  <= 1'b0;
        prdata  <= 32'h0;
        pslverr <= 1'b0;
      end
    end
  end

endmodule // sps_stats

// File: rtl/sps_stats_map.svh
// sps_stats_map.svh: register offsets, geometry and reset values of the port statistics block
// assumes: included by the package, the top module and the datapath model, no other definitions
`ifndef SPS_STATS_MAP_SVH
`define SPS_STATS_MAP_SVH

// per-port window: 64 words (256 bytes), port n at n * 0x100
`define SPS_PORT_STRIDE_LOG2     8
`define SPS_WORD_IDX_W           6
// word indices inside a port window
`define SPS_IDX_UNI_FRAMES       6'h00
`define SPS_IDX_UNI_BYTES        6'h01
`define SPS_IDX_MLT_FRAMES       6'h02
`define SPS_IDX_MLT_BYTES        6'h03
`define SPS_IDX_BRD_FRAMES       6'h04
`define SPS_IDX_BRD_BYTES        6'h05
`define SPS_IDX_MEMPROT_FRAMES   6'h06
// per-priority groups of eight words
`define SPS_IDX_PRI_FRAMES_BASE  6'h08
`define SPS_IDX_PRI_BYTES_BASE   6'h10
`define SPS_IDX_DROP_FRAMES_BASE 6'h18
`define SPS_IDX_DROP_BYTES_BASE  6'h20
`define SPS_NUM_SCALAR           7
`define SPS_NUM_PRI              8
`define SPS_MIN_GOOD_LEN         14'h0040
`define SPS_RECEIVE_MAX_FRAME_LENGTH_RESET      14'h05ee
`define SPS_CNT_RESET            32'h0000_0000
`define SPS_RDATA_ERR            32'h0000_0000

`endif

// File: rtl/sps_stats_pkg.sv
// sps_stats_pkg: types shared by the port statistics block
// assumes: sps_stats_map.svh is on the include path
package sps_stats_pkg;
  `include "sps_stats_map.svh"

  typedef logic [31:0] sps_cnt_t;
  typedef logic [13:0] sps_len_t;

  // destination class reported by the lookup engine
  typedef enum logic [1:0] {
    SPS_DST_UNI = 2'b00,
    SPS_DST_MLT = 2'b01,
    SPS_DST_BRD = 2'b10,
    SPS_DST_RSV = 2'b11
  } sps_dst_e;
endpackage

// File: tb/sps_stats_properties.sv
// sps_stats_properties: bus-side assertions for the port statistics block
// assumes: bound into sps_stats, one pclk domain
`timescale 1ns/1ps
module sps_stats_properties #(
  parameter int NPORTS = 5 // switch ports
) (
  input wire logic        pclk, presetn, clk_en, // clock, reset, run
  input wire logic        psel, penable, pwrite, // apb request
  input wire logic [15:0] paddr,                 // byte address
  input wire logic [31:0] prdata,                // read data
  input wire logic        pready, pslverr        // apb answer
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // idx 7 and anything past idx 39 are holes in each port window
  wire logic ok;
  assign ok = paddr[1:0] == 2'h0 && paddr[15:8] < NPORTS && paddr[7:0] <= 8'h9c
    && (paddr[7:0] <= 8'h18 || paddr[7:0] >= 8'h20);
  sequence s_req; psel && penable && clk_en && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  one_wait_a: assert property (s_req |=> s_done)
    else $error("pready late or held");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  ready_single_a: assert property (pready |-> !$past(pready))
    else $error("pready two cycles");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata outside answer");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  write_refused_a: assert property (pready && pwrite |-> pslverr && prdata == 32'h0)
    else $error("write not refused");
  unmapped_err_a: assert property (pready && !ok |-> pslverr && prdata == 32'h0)
    else $error("hole not refused");
  mapped_ok_a: assert property (pready && !pwrite && ok |-> !pslverr)
    else $error("mapped read refused");
endmodule // sps_stats_properties

bind sps_stats sps_stats_properties #(.NPORTS(NPORTS)) i_props (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// File: tb/sps_dpath_model.sv
// sps_dpath_model: switch datapath and lookup engine issuing counter events
// assumes: ev is called just after a rising pclk edge
`timescale 1ns/1ps
`include "sps_stats_map.svh"
module sps_dpath_model
  import sps_stats_pkg::*;
#(
  parameter int PW = 3 // port index width
) (
  input  wire logic pclk,                                           // clock
  output logic      rx_valid, rx_data, rx_sa_unknown, rx_err,       // rx report
  output sps_dst_e  rx_dst,                                         // rx class
  output logic      tx_valid, tx_retry, tx_pause, mp_valid, drop_valid, // tx
  output logic [PW-1:0] rx_port, tx_port, mp_port, drop_port,       // ports
  output logic [2:0]    tx_pri, drop_pri,                           // priorities
  output sps_len_t  rx_len, tx_len, drop_len, receive_max_frame_length // lengths
);
  assign receive_max_frame_length = `SPS_RECEIVE_MAX_FRAME_LENGTH_RESET;
  initial begin
    {rx_valid, rx_data, rx_sa_unknown, rx_err, tx_valid, tx_retry, tx_pause, mp_valid,
     drop_valid, rx_port, tx_port, mp_port, drop_port, tx_pri, drop_pri} = '0;
    {rx_len, tx_len, drop_len} = '0;
    rx_dst = SPS_DST_UNI;
  end
  // k: 0 rx, 1 tx, 2 memory-protect, 3 drop; f: rx {err,unknown,data}, tx {pause,retry}
  task automatic ev(input int k, p, s, input sps_len_t l, input logic [2:0] f);
    case (k)
      0: begin
        {rx_valid, rx_port, rx_len} <= {1'b1, PW'(p), l};
        rx_dst <= sps_dst_e'(2'(s));
        {rx_err, rx_sa_unknown, rx_data} <= f;
      end
      1: {tx_valid, tx_port, tx_pri, tx_len, tx_pause, tx_retry} <= {1'b1, PW'(p), 3'(s), l, f[1:0]};
      2: {mp_valid, mp_port} <= {1'b1, PW'(p)};
      default: {drop_valid, drop_port, drop_pri, drop_len} <= {1'b1, PW'(p), 3'(s), l};
    endcase
    @(posedge pclk);
    {rx_valid, tx_valid, mp_valid, drop_valid} <= '0;
    // stale lengths must not look valid once the pulse is gone
    {rx_len, tx_len, drop_len} <= ~{rx_len, tx_len, drop_len};
  endtask
endmodule // sps_dpath_model

// File: tb/tb_switch_port_stats_counters.sv
// tb_switch_port_stats_counters: table-driven check of the port statistics block
// assumes: design, datapath model and bound checker compiled before it
`timescale 1ns/1ps
module tb_switch_port_stats_counters;
  import sps_stats_pkg::*;
  localparam int PW = 3;
  typedef struct {int k, p, s; sps_len_t l; logic [2:0] f; logic [15:0] a; logic [31:0] e;} sps_row_s;
  logic          pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [15:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic          rx_valid, rx_data, rx_sa_unknown, rx_err, tx_valid, tx_retry, tx_pause;
  logic          mp_valid, drop_valid;
  logic [PW-1:0] rx_port, tx_port, mp_port, drop_port;
  logic [2:0]    tx_pri, drop_pri;
  sps_dst_e      rx_dst;
  sps_len_t      rx_len, tx_len, drop_len, receive_max_frame_length;
  int            mismatches, checks;
  logic [15:0]   holes[3] = '{16'h01c, 16'h500, 16'h102};
  sps_row_s rows[17] = '{
    '{0, 1, 0, 14'h40, 3, 16'h100, 32'h1}, '{0, 1, 0, 14'h5ee, 3, 16'h104, 32'h62e},
    '{0, 1, 0, 14'h3f, 3, 16'h100, 32'h2}, '{0, 1, 0, 14'h5ef, 3, 16'h100, 32'h2},
    '{0, 1, 0, 14'h64, 7, 16'h104, 32'h62e}, '{0, 1, 0, 14'h64, 1, 16'h100, 32'h2},
    '{0, 1, 0, 14'h64, 2, 16'h100, 32'h2}, '{0, 2, 1, 14'hc8, 3, 16'h208, 32'h1},
    '{0, 2, 1, 14'h5ee, 3, 16'h20c, 32'h6b6}, '{0, 2, 2, 14'h40, 3, 16'h210, 32'h1},
    '{0, 2, 2, 14'h41, 3, 16'h214, 32'h81}, '{2, 4, 0, 14'h0, 0, 16'h418, 32'h1},
    '{1, 0, 7, 14'ha, 0, 16'h03c, 32'h1}, '{1, 0, 7, 14'h14, 1, 16'h03c, 32'h1},
    '{1, 0, 7, 14'h14, 2, 16'h05c, 32'ha}, '{3, 3, 0, 14'h5a, 0, 16'h360, 32'h1},
    '{3, 3, 0, 14'h5, 0, 16'h380, 32'h5f}};
  sps_stats #(.NPORTS(5)) i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_port, .rx_dst, .rx_data, .rx_sa_unknown,
    .rx_err, .rx_len, .receive_max_frame_length, .tx_valid, .tx_port, .tx_pri, .tx_retry,
    .tx_pause, .tx_len, .mp_valid, .mp_port, .drop_valid, .drop_port, .drop_pri, .drop_len);
  sps_dpath_model #(.PW(PW)) i_dp (.pclk, .rx_valid, .rx_data, .rx_sa_unknown, .rx_err, .rx_dst,
    .tx_valid, .tx_retry, .tx_pause, .mp_valid, .drop_valid, .rx_port, .tx_port, .mp_port,
    .drop_port, .tx_pri, .drop_pri, .rx_len, .tx_len, .drop_len, .receive_max_frame_length);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer; idle edge afterwards keeps psel from being set twice in a step
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] xd, input logic xe);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, {32{w}}};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk(prdata, xd);
    chk({31'h0, pslverr}, {31'h0, xe});
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = {5'b01000, 48'h0};
    {mismatches, checks} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(1'b0, 16'h000, 32'h0, 1'b0);
    foreach (rows[i]) begin
      i_dp.ev(rows[i].k, rows[i].p, rows[i].s, rows[i].l, rows[i].f);
      acc(1'b0, rows[i].a, rows[i].e, 1'b0);
    end
    for (int m = 0; m < 8; m++) begin
      i_dp.ev(1, 4, m, 14'(m + 1), 3'h0);
      acc(1'b0, 16'h420 + 16'(4 * m), 32'h1, 1'b0);
      acc(1'b0, 16'h440 + 16'(4 * m), 32'(m + 1), 1'b0);
    end
    foreach (holes[i]) acc(1'b0, holes[i], 32'h0, 1'b1);
    // frozen clock enable drops the event; the reserved class never counts
    clk_en <= 1'b0;
    i_dp.ev(0, 1, 0, 14'h40, 3'h3);
    clk_en <= 1'b1;
    acc(1'b0, 16'h100, 32'h2, 1'b0);
    i_dp.ev(0, 1, 3, 14'h40, 3'h3);
    acc(1'b0, 16'h100, 32'h2, 1'b0);
    acc(1'b1, 16'h100, 32'h0, 1'b1);
    acc(1'b0, 16'h100, 32'h2, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(1'b0, 16'h104, 32'h0, 1'b0);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
endmodule // tb_switch_port_stats_counters
